// ### rtl/amcg_top.sv
// The register addresses and the AXI4-Lite register port are this design's own decisions.
module amcg_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register bus
    input wire amcg_pkg::amcg_axi_req_t axi_req,
    output amcg_pkg::amcg_axi_rsp_t axi_rsp,
    // frame events
    input wire logic frame_start,
    input wire logic pseudo_frame_start,
    // clocks
    input wire logic master_clock_in,
    output logic master_clock_out,
    output logic secondary_master_clock,
    output logic codec_port_clock
);
    import amcg_pkg::*;

    typedef struct packed {
        logic [7:0] stage_high;
        logic [7:0] stage_mid;
        logic [FREQ_W-1:0] freq_word;
        logic [7:0] div_ctrl;
        logic [7:0] gen_ctrl;
        logic [15:0] cap_cnt;
        logic [15:0] cap_reg;
        logic [7:0] cap_shadow_high;
        logic sof_s1;
        logic sof_s2;
        logic sof_s3;
        logic mcki_s1;
        logic mcki_s2;
        logic codec_clk;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [7:0] w_data;
        logic w_lane0;
        amcg_axi_rsp_t rsp;
    } amcg_st_t;

    amcg_st_t st_ff;
    amcg_st_t nxt_st;
    logic synth_clk;
    logic synth_rise;
    logic mclk;
    logic mclk_rise;
    logic frame_evt;
    logic cap_tick;
    logic wr_fire;
    logic [7:0] rd_byte;
    logic rd_hit;

    // synthesizer and output divider
    amcg_synth u_synth (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(st_ff.gen_ctrl[CTL_RUN]),
        .freq_word(st_ff.freq_word),
        .div_m(st_ff.div_ctrl[DIV_M_LSB +: DIV_M_W]),
        .synth_clk(synth_clk),
        .synth_rise(synth_rise),
        .mclk(mclk),
        .mclk_rise(mclk_rise)
    );

    // frame event from synchronised pin or internal pseudo frame pulse
    assign frame_evt = (st_ff.sof_s2 & ~st_ff.sof_s3) | pseudo_frame_start;
    // capture clock edge chosen by the control bit
    assign cap_tick = st_ff.gen_ctrl[CTL_CAP_SEL] ? synth_rise
                                                  : mclk_rise;

    // read data mux
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        unique case (axi_req.araddr)
            OFS_FREQ_HIGH: rd_byte = st_ff.freq_word[23:16];
            OFS_FREQ_MID: rd_byte = st_ff.freq_word[15:8];
            OFS_FREQ_LOW: rd_byte = st_ff.freq_word[7:0];
            OFS_CAP_HIGH: rd_byte = st_ff.cap_shadow_high;
            OFS_CAP_LOW: rd_byte = st_ff.cap_reg[7:0];
            OFS_DIV_CTRL: rd_byte = st_ff.div_ctrl;
            OFS_GEN_CTRL: rd_byte = st_ff.gen_ctrl;
            default: rd_hit = 1'b0;
        endcase
    end

    // next state: bus slave, registers, capture, clock select
    always_comb begin
        nxt_st = st_ff;
        wr_fire = 1'b0;
        // two-flop synchronisers, edge detect on the second stage
        nxt_st.sof_s1 = frame_start;
        nxt_st.sof_s2 = st_ff.sof_s1;
        nxt_st.sof_s3 = st_ff.sof_s2;
        nxt_st.mcki_s1 = master_clock_in;
        nxt_st.mcki_s2 = st_ff.mcki_s1;
        // codec port clock source
        if (st_ff.gen_ctrl[CTL_EXT_CLK]) begin
            nxt_st.codec_clk = st_ff.mcki_s2;
        end else begin
            nxt_st.codec_clk = mclk;
        end
        // free running wrap-around counter
        if (cap_tick) begin
            nxt_st.cap_cnt = st_ff.cap_cnt + 16'h0001;
        end
        // latch on every frame event, held until the next
        if (frame_evt) begin
            nxt_st.cap_reg = st_ff.cap_cnt;
        end
        // write address and data taken in either order
        if (axi_req.awvalid && st_ff.rsp.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_ff.rsp.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = axi_req.wdata[7:0];
            nxt_st.w_lane0 = axi_req.wstrb[0];
        end
        if (st_ff.rsp.bvalid && axi_req.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        if (nxt_st.aw_got && nxt_st.w_got) begin
            wr_fire = 1'b1;
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = RESP_OKAY;
            unique case (nxt_st.aw_addr)
                OFS_FREQ_HIGH: begin
                    if (nxt_st.w_lane0) begin
                        nxt_st.stage_high = nxt_st.w_data;
                    end
                end
                OFS_FREQ_MID: begin
                    if (nxt_st.w_lane0) begin
                        nxt_st.stage_mid = nxt_st.w_data;
                    end
                end
                OFS_FREQ_LOW: begin
                    // commit without stopping the synthesizer
                    if (nxt_st.w_lane0) begin
                        nxt_st.freq_word = {st_ff.stage_high, st_ff.stage_mid,
                                            nxt_st.w_data};
                    end
                end
                OFS_DIV_CTRL: begin
                    if (nxt_st.w_lane0) begin
                        nxt_st.div_ctrl = nxt_st.w_data;
                    end
                end
                OFS_GEN_CTRL: begin
                    if (nxt_st.w_lane0) begin
                        nxt_st.gen_ctrl = nxt_st.w_data;
                    end
                end
                OFS_CAP_HIGH, OFS_CAP_LOW: begin
                end
                default: nxt_st.rsp.bresp = RESP_SLVERR;
            endcase
        end
        // read channel
        if (st_ff.rsp.rvalid && axi_req.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_ff.rsp.arready) begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata = {24'h000000, rd_byte};
            nxt_st.rsp.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
            // low byte read freezes the matching high byte
            if (axi_req.araddr == OFS_CAP_LOW) begin
                nxt_st.cap_shadow_high = st_ff.cap_reg[15:8];
            end
        end
        nxt_st.rsp.awready = ~nxt_st.aw_got & ~nxt_st.rsp.bvalid;
        nxt_st.rsp.wready = ~nxt_st.w_got & ~nxt_st.rsp.bvalid;
        nxt_st.rsp.arready = ~nxt_st.rsp.rvalid;
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.stage_high <= FREQ_RST[23:16];
            st_ff.stage_mid <= FREQ_RST[15:8];
            st_ff.freq_word <= FREQ_RST;
            st_ff.div_ctrl <= DIV_CTRL_RST;
            st_ff.gen_ctrl <= GEN_CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs, all from flops
    assign axi_rsp = st_ff.rsp;
    assign master_clock_out = mclk;
    assign secondary_master_clock = synth_clk;
    assign codec_port_clock = st_ff.codec_clk;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_low_commits_word: assert property (
        wr_fire && nxt_st.aw_addr == OFS_FREQ_LOW && nxt_st.w_lane0
        |=> st_ff.freq_word == {$past(st_ff.stage_high),
                                $past(st_ff.stage_mid), $past(nxt_st.w_data)})
        else $error("low byte write did not commit the staged word");
    a_upper_only_stage: assert property (
        !(wr_fire && nxt_st.aw_addr == OFS_FREQ_LOW)
        |=> $stable(st_ff.freq_word))
        else $error("frequency word changed without a low byte write");
    a_counter_steps: assert property (
        cap_tick |=> st_ff.cap_cnt == 16'($past(st_ff.cap_cnt) + 16'h0001))
        else $error("capture counter did not step on its clock");
    a_counter_idle: assert property (!cap_tick |=> $stable(st_ff.cap_cnt))
        else $error("capture counter moved without a clock edge");
    a_mclk_selected: assert property (
        !st_ff.gen_ctrl[CTL_CAP_SEL] && mclk_rise
        ##1 !st_ff.gen_ctrl[CTL_CAP_SEL]
        |-> st_ff.cap_cnt != $past(st_ff.cap_cnt))
        else $error("master clock edge not counted when selected");
    a_capture_load: assert property (
        frame_evt |=> st_ff.cap_reg == $past(st_ff.cap_cnt))
        else $error("frame event did not load the capture register");
    a_capture_hold: assert property (!frame_evt |=> $stable(st_ff.cap_reg))
        else $error("capture register changed between frame events");
    a_ext_clock_src: assert property (
        st_ff.gen_ctrl[CTL_EXT_CLK] |=> codec_port_clock == $past(st_ff.mcki_s2))
        else $error("codec clock not taken from external input");
    a_gen_clock_src: assert property (
        !st_ff.gen_ctrl[CTL_EXT_CLK] |=> codec_port_clock == $past(mclk))
        else $error("codec clock not taken from generated clock");
    a_high_coherent: assert property (
        axi_req.arvalid && st_ff.rsp.arready && axi_req.araddr == OFS_CAP_HIGH
        |=> st_ff.rsp.rdata[7:0] == $past(st_ff.cap_shadow_high))
        else $error("capture high byte not from the frozen copy");

    c_frame_capture: cover property (frame_evt ##1 st_ff.cap_reg != 16'h0000);
    c_freq_commit: cover property (wr_fire && nxt_st.aw_addr == OFS_FREQ_LOW);
    c_ext_clock: cover property (st_ff.gen_ctrl[CTL_EXT_CLK] && st_ff.mcki_s2);
    c_cap_pair_read: cover property (
        axi_req.arvalid && st_ff.rsp.arready && axi_req.araddr == OFS_CAP_LOW
        ##[1:20] axi_req.arvalid && st_ff.rsp.arready
        && axi_req.araddr == OFS_CAP_HIGH);
endmodule : amcg_top

// ### rtl/amcg_pkg.sv
package amcg_pkg;
    // register map, one aligned 32-bit word each, data in bits 7:0
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_FREQ_HIGH = 8'h00;
    localparam logic [7:0] OFS_FREQ_MID = 8'h04;
    localparam logic [7:0] OFS_FREQ_LOW = 8'h08;
    localparam logic [7:0] OFS_CAP_HIGH = 8'h0c;
    localparam logic [7:0] OFS_CAP_LOW = 8'h10;
    localparam logic [7:0] OFS_DIV_CTRL = 8'h14;
    localparam logic [7:0] OFS_GEN_CTRL = 8'h18;

    // reset values
    localparam logic [23:0] FREQ_RST = 24'h61a800;
    localparam logic [7:0] DIV_CTRL_RST = 8'h00;
    localparam logic [7:0] GEN_CTRL_RST = 8'h04;

    // frequency word: 6 integer bits, 18 fraction bits
    localparam int FREQ_W = 24;
    localparam int FRAC_W = 18;
    localparam logic [23:0] DIVISOR_MIN = 24'h600000;
    localparam logic [23:0] DIVISOR_MAX = 24'hc80000;
    // accumulator step per system cycle (12.0 in the same format)
    localparam logic [24:0] SYNTH_STEP = 25'h0300000;

    // field positions
    localparam int DIV_M_LSB = 0;
    localparam int DIV_M_W = 4;
    localparam int CTL_CAP_SEL = 0;
    localparam int CTL_EXT_CLK = 1;
    localparam int CTL_RUN = 2;

    // bus
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } amcg_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } amcg_axi_rsp_t;
endpackage : amcg_pkg

// ### rtl/amcg_synth.sv
// fractional synthesizer followed by the divide-by-M stage
module amcg_synth (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic [amcg_pkg::FREQ_W-1:0] freq_word,
    input wire logic [amcg_pkg::DIV_M_W-1:0] div_m,
    // clocks out
    output logic synth_clk,
    output logic synth_rise,
    output logic mclk,
    output logic mclk_rise
);
    import amcg_pkg::*;

    typedef struct packed {
        logic [24:0] acc;
        logic tick;
        logic synth_clk;
        logic synth_rise;
        logic [DIV_M_W-1:0] div_cnt;
        logic mclk;
        logic mclk_rise;
    } amcg_synth_st_t;

    amcg_synth_st_t st_ff;
    amcg_synth_st_t nxt_st;
    logic [23:0] divisor;
    logic [24:0] sum;

    // clamp the divisor into its legal range, applied on the fly
    always_comb begin
        nxt_st = st_ff;
        divisor = freq_word;
        if (freq_word < DIVISOR_MIN) begin
            divisor = DIVISOR_MIN;
        end else if (freq_word > DIVISOR_MAX) begin
            divisor = DIVISOR_MAX;
        end
        sum = st_ff.acc + SYNTH_STEP;
        nxt_st.tick = 1'b0;
        nxt_st.synth_rise = 1'b0;
        nxt_st.mclk_rise = 1'b0;
        if (run) begin
            // one tick per synthesizer half period, never two in a row:
            // a smaller word committed mid-run must not overspeed the clock
            if (sum >= {1'b0, divisor} && !st_ff.tick) begin
                nxt_st.acc = sum - {1'b0, divisor};
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.acc = sum;
            end
        end
        if (st_ff.tick) begin
            nxt_st.synth_clk = ~st_ff.synth_clk;
            nxt_st.synth_rise = ~st_ff.synth_clk;
            // toggle every M half periods: 50% for odd and even M
            if (st_ff.div_cnt >= div_m) begin
                nxt_st.div_cnt = '0;
                nxt_st.mclk = ~st_ff.mclk;
                nxt_st.mclk_rise = ~st_ff.mclk;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign synth_clk = st_ff.synth_clk;
    assign synth_rise = st_ff.synth_rise;
    assign mclk = st_ff.mclk;
    assign mclk_rise = st_ff.mclk_rise;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    a_synth_max_rate: assert property (st_ff.tick |=> !st_ff.tick)
        else $error("synthesizer ticks faster than its upper limit");
    a_mclk_half_len: assert property (
        st_ff.tick && st_ff.div_cnt < div_m && $stable(div_m)
        |=> $stable(st_ff.mclk))
        else $error("master clock toggled before M half periods");
    a_mclk_toggle: assert property (
        st_ff.tick && st_ff.div_cnt == div_m |=> $changed(st_ff.mclk))
        else $error("master clock missed its toggle");
endmodule : amcg_synth

// ### tb/amcg_ext_osc.sv
// external master clock source standing on the codec side of the pin
module amcg_ext_osc #(
    parameter int HALF = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control and pin
    input wire logic enable,
    output logic master_clock_in
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;

    // oscillator runs only when enabled, otherwise the pin stands low
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst || !enable) begin
            cnt <= 0;
            master_clock_in <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            master_clock_in <= !master_clock_in;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : amcg_ext_osc

// ### tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import amcg_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    amcg_axi_req_t req = '0;
    amcg_axi_rsp_t rsp;
    logic fs = 1'b0;
    logic pfs = 1'b0;
    logic ext_en = 1'b0;
    logic mci, mco, mco2, codec;
    logic mco_p = 1'b0;
    logic mco2_p = 1'b0;
    logic mco_d = 1'b0;
    logic [2:0] mci_d = '0;
    logic [15:0] cnt = '0;
    logic [7:0] m_gen = GEN_CTRL_RST;
    logic [15:0] e;
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
    int failures = 0;
    int cmp_count = 0;
    int track = 0;
    int hi, lo;
    int mt[4] = '{1, 2, 5, 16};

    always #12.5 sys_clk = !sys_clk;

    amcg_top uut (.sys_clk(sys_clk), .nrst(nrst), .axi_req(req),
        .axi_rsp(rsp), .frame_start(fs), .pseudo_frame_start(pfs),
        .master_clock_in(mci), .master_clock_out(mco),
        .secondary_master_clock(mco2), .codec_port_clock(codec));
    amcg_ext_osc osc (.sys_clk(sys_clk), .nrst(nrst), .enable(ext_en),
        .master_clock_in(mci));

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wait_clk

    // write cycle: address and data offered together, released when taken
    task automatic axi_write(input logic [7:0] ad, input logic [7:0] v,
            output logic [1:0] resp);
        req.awaddr <= ad;
        req.wdata <= {24'h0, v};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        resp = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge sys_clk);
    endtask : axi_write

    // read cycle: data and response taken at the rvalid edge
    task automatic axi_read(input logic [7:0] ad, output logic [31:0] v,
            output logic [1:0] resp);
        req.araddr <= ad;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge sys_clk);
    endtask : axi_read

    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        logic [1:0] resp;
        axi_write(ad, v, resp);
        check("bresp", 32'(resp), 32'(RESP_OKAY));
        if (ad == OFS_GEN_CTRL) m_gen = v;
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [7:0] v,
            input string what);
        logic [31:0] x;
        logic [1:0] resp;
        axi_read(ad, x, resp);
        check(what, x, {24'h0, v});
        check("rresp", 32'(resp), 32'(RESP_OKAY));
    endtask : rd

    function automatic logic sig(input bit s);
        return s ? mco2 : mco;
    endfunction : sig

    // high and low widths in cycles, taken from the third full period
    task automatic measure(input bit s, output int h, output int l);
        repeat (2) begin
            while (sig(s) !== 1'b0) @(posedge sys_clk);
            while (sig(s) !== 1'b1) @(posedge sys_clk);
            h = 0;
            l = 0;
            do begin @(posedge sys_clk); h++; end while (sig(s) === 1'b1);
            do begin @(posedge sys_clk); l++; end while (sig(s) === 1'b0);
        end
    endtask : measure

    task automatic soft_frame();
        pfs <= 1'b1;
        @(posedge sys_clk);
        pfs <= 1'b0;
        wait_clk(5);
        e = cnt;
    endtask : soft_frame

    // model of the capture counter and of the codec clock path
    always @(posedge sys_clk) begin
        if (nrst && (m_gen[0] ? (mco2 && !mco2_p) : (mco && !mco_p)))
            cnt <= cnt + 16'h1;
        mco_p <= mco;
        mco2_p <= mco2;
        mco_d <= mco;
        mci_d <= {mci_d[1:0], mci};
        if (track == 1) check("codec_port_clock", 32'(codec), 32'(mco_d));
        if (track == 2) check("codec_ext", 32'(codec), 32'(mci_d[2]));
    end

    // watchdog
    initial begin
        wait_clk(40000);
        failures++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hed92));
        wait_clk(5);
        nrst <= 1'b1;
        wait_clk(2);
        // reset values
        rd(OFS_FREQ_HIGH, FREQ_RST[23:16], "freq_word_high");
        rd(OFS_FREQ_MID, FREQ_RST[15:8], "freq_word_mid");
        rd(OFS_FREQ_LOW, FREQ_RST[7:0], "freq_word_low_commit");
        rd(OFS_DIV_CTRL, DIV_CTRL_RST, "output_divider_ctrl");
        rd(OFS_GEN_CTRL, GEN_CTRL_RST, "clock_gen_ctrl");
        rd(OFS_CAP_LOW, 8'h00, "capture_count_low");
        // unmapped address refused
        a = 8'h1c + 8'($urandom_range(0, 56)) * 8'h4;
        axi_read(a, d, r);
        check("rresp_unmapped", 32'(r), 32'(RESP_SLVERR));
        check("rdata_unmapped", d, 32'h0);
        axi_write(a, 8'($urandom), r);
        check("bresp_unmapped", 32'(r), 32'(RESP_SLVERR));
        // upper bytes only staged until the low byte commits
        wr(OFS_FREQ_HIGH, 8'($urandom_range(8'h60, 8'hc8)));
        wr(OFS_FREQ_MID, 8'($urandom));
        rd(OFS_FREQ_HIGH, FREQ_RST[23:16], "freq_word_high");
        wr(OFS_FREQ_HIGH, 8'h60);
        wr(OFS_FREQ_MID, 8'h00);
        wr(OFS_FREQ_LOW, 8'h00);
        rd(OFS_FREQ_HIGH, 8'h60, "freq_word_high");
        rd(OFS_FREQ_MID, 8'h00, "freq_word_mid");
        rd(OFS_FREQ_LOW, 8'h00, "freq_word_low_commit");
        track = 1;
        // divisor 24: synth half period 2 cycles, master clock 2*M each
        foreach (mt[i]) begin
            wr(OFS_DIV_CTRL, 8'(mt[i] - 1));
            measure(0, hi, lo);
            check("mclk_high", 32'(hi), 32'(2 * mt[i]));
            check("mclk_low", 32'(lo), 32'(2 * mt[i]));
        end
        measure(1, hi, lo);
        check("synth_half", 32'(hi), 32'h2);
        // new word while running: divisor 48 doubles the synth period
        wr(OFS_FREQ_HIGH, 8'hc0);
        wr(OFS_FREQ_MID, 8'h00);
        wr(OFS_FREQ_LOW, 8'h00);
        measure(1, hi, lo);
        check("synth_half", 32'(hi), 32'h4);
        check("synth_low", 32'(lo), 32'h4);
        measure(0, hi, lo);
        check("mclk_high", 32'(hi), 32'd64);
        // one LSB nudge of the running word lands in the active word
        wr(OFS_FREQ_LOW, 8'h01);
        rd(OFS_FREQ_LOW, 8'h01, "freq_word_low_commit");
        rd(OFS_FREQ_HIGH, 8'hc0, "freq_word_high");
        // external master clock to the codec port
        track = 0;
        ext_en <= 1'b1;
        wr(OFS_GEN_CTRL, 8'h06);
        wait_clk(10);
        track = 2;
        wait_clk(200);
        track = 0;
        wr(OFS_GEN_CTRL, 8'h04);
        ext_en <= 1'b0;
        // capture of master clock rises, clocks stopped for a stable count
        wr(OFS_GEN_CTRL, 8'h00);
        wait_clk(20);
        soft_frame();
        rd(OFS_CAP_LOW, e[7:0], "capture_count_low");
        rd(OFS_CAP_HIGH, e[15:8], "capture_count_high");
        // secondary clock counted, event from the frame pin
        wr(OFS_GEN_CTRL, 8'h01);
        wr(OFS_GEN_CTRL, 8'h05);
        wait_clk(3000);
        wr(OFS_GEN_CTRL, 8'h01);
        wait_clk(20);
        fs <= 1'b1;
        wait_clk(4);
        fs <= 1'b0;
        wait_clk(10);
        e = cnt;
        rd(OFS_CAP_LOW, e[7:0], "capture_count_low");
        rd(OFS_CAP_HIGH, e[15:8], "capture_count_high");
        // new capture between the two byte reads
        wr(OFS_GEN_CTRL, 8'h05);
        rd(OFS_CAP_LOW, e[7:0], "capture_count_low");
        wait_clk(3000);
        wr(OFS_GEN_CTRL, 8'h01);
        wait_clk(20);
        a = e[15:8];
        soft_frame();
        rd(OFS_CAP_HIGH, a, "capture_count_high");
        rd(OFS_CAP_LOW, e[7:0], "capture_count_low");
        rd(OFS_CAP_HIGH, e[15:8], "capture_count_high");
        give_verdict();
    end
endmodule : tb
